//--- hdl/paxc_core.sv
// Two-axis positioning command handler with AXI4-Lite register slave
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module paxc_core #(
    parameter int MCW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] axis_moving,
    input wire logic [1:0] axis_decel,
    input wire logic [1:0] axis_dwell,
    input wire logic [1:0] pos_step,
    input wire logic [1:0] pos_dir,
    input wire logic [1:0] mcode_set,
    input wire logic [MCW-1:0] mcode_value,
    output logic [1:0] halt_pulse,
    output logic [1:0] output_inhibit,
    output logic [1:0] speed_load,
    output logic [1:0][16:0] override_speed,
    output logic [1:0] inch_start,
    output logic [31:0] inching_distance,
    output logic [16:0] inching_speed,
    output logic [1:0][6:0] step_number,
    output logic [1:0] home_determined,
    output logic cmd_done,
    output logic [9:0] cmd_status,
    output logic irq
);
    // Aux code number must fit half a read word
    if (MCW < 1 || MCW > 16) begin : g_chk
        $error("MCW must be 1 to 16");
    end

    localparam int NREQ = paxc_pkg::NREQ;

    typedef struct packed {
        logic aw_ok;
        logic [7:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NREQ-1:0] req;
        logic sel;
        logic [31:0] arg0;
        logic [31:0] arg1;
        logic [16:0] inch_spd;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic irq_lvl;
        logic [9:0] code;
        logic done;
        logic [1:0][31:0] pos;
        logic [1:0][6:0] step;
        logic [1:0] mact;
        logic [1:0][MCW-1:0] mnum;
        logic [1:0] home;
        logic [1:0] emg;
        logic [1:0] inh;
        logic [1:0] arm;
        logic [1:0][31:0] trig;
        logic [1:0][16:0] spd;
        logic [1:0] spd_load;
        logic [1:0] halt;
        logic [1:0] inch_go;
        logic [31:0] inch_dist;
    } paxc_state_s;

    paxc_state_s st;
    paxc_state_s n;
    paxc_pkg::paxc_cmd_e cmd;
    logic [NREQ-1:0] go;
    logic wr;
    logic a;
    logic spd_ok;
    logic step_ok;

    function automatic logic [31:0] paxc_merge(
        input logic [31:0] o,
        input logic [31:0] d,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    assign s_axi_awready = !st.aw_ok;
    assign s_axi_wready = !st.w_ok;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign halt_pulse = st.halt;
    assign output_inhibit = st.inh;
    assign speed_load = st.spd_load;
    assign override_speed = st.spd;
    assign inch_start = st.inch_go;
    assign inching_distance = st.inch_dist;
    assign inching_speed = st.inch_spd;
    assign step_number = st.step;
    assign home_determined = st.home;
    assign cmd_done = st.done;
    assign cmd_status = st.code;
    assign irq = st.irq_lvl;

    // ==========================================================
    // Next state
    always_comb begin
        n = st;
        n.spd_load = '0;
        n.halt = '0;
        n.inch_go = '0;
        n.done = 1'b0;
        go = '0;
        cmd = paxc_pkg::C_NONE;
        wr = st.aw_ok && st.w_ok && !st.bvalid;
        // ======================================================
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !st.aw_ok) begin
            n.aw_ok = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_ok) begin
            n.w_ok = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (wr) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = paxc_pkg::RESP_OK;
            unique case (st.awaddr)
                paxc_pkg::A_CMD: begin
                    if (st.wstrb[1]) begin
                        n.sel = st.wdata[paxc_pkg::B_SEL];
                    end
                    if (st.wstrb[0]) begin
                        go = st.wdata[NREQ-1:0] & ~st.req;
                        n.req = st.wdata[NREQ-1:0];
                    end
                end
                paxc_pkg::A_ARG0: begin
                    n.arg0 = paxc_merge(st.arg0, st.wdata, st.wstrb);
                end
                paxc_pkg::A_ARG1: begin
                    n.arg1 = paxc_merge(st.arg1, st.wdata, st.wstrb);
                end
                paxc_pkg::A_INCH: begin
                    n.inch_spd = 17'(paxc_merge(32'(st.inch_spd),
                        st.wdata, st.wstrb));
                end
                paxc_pkg::A_IRQS: begin
                    if (st.wstrb[0]) begin
                        n.irq_st = st.irq_st & ~st.wdata[1:0];
                    end
                end
                paxc_pkg::A_IRQM: begin
                    if (st.wstrb[0]) begin
                        n.irq_mask = st.wdata[1:0];
                    end
                end
                paxc_pkg::A_STAT, paxc_pkg::A_FLAG, paxc_pkg::A_POSX,
                paxc_pkg::A_POSY, paxc_pkg::A_MCODE, paxc_pkg::A_STEP: begin
                end
                default: begin
                    n.bresp = paxc_pkg::RESP_ERR;
                end
            endcase
        end
        // ======================================================
        // Read channel, data registered
        if (st.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            n.rvalid = 1'b1;
            n.rresp = paxc_pkg::RESP_OK;
            n.rdata = '0;
            unique case (s_axi_araddr)
                paxc_pkg::A_CMD: n.rdata = {23'h0, st.sel, 1'b0, st.req};
                paxc_pkg::A_ARG0: n.rdata = st.arg0;
                paxc_pkg::A_ARG1: n.rdata = st.arg1;
                paxc_pkg::A_INCH: n.rdata = {15'h0, st.inch_spd};
                paxc_pkg::A_STAT: n.rdata = {22'h0, st.code};
                paxc_pkg::A_IRQS: n.rdata = {30'h0, st.irq_st};
                paxc_pkg::A_IRQM: n.rdata = {30'h0, st.irq_mask};
                paxc_pkg::A_FLAG: n.rdata = {22'h0, st.arm, st.mact,
                    st.home, st.emg, st.inh};
                paxc_pkg::A_POSX: n.rdata = st.pos[0];
                paxc_pkg::A_POSY: n.rdata = st.pos[1];
                paxc_pkg::A_MCODE: n.rdata = {16'(st.mnum[1]),
                    16'(st.mnum[0])};
                paxc_pkg::A_STEP: n.rdata = {17'h0, st.step[1], 1'b0,
                    st.step[0]};
                default: n.rresp = paxc_pkg::RESP_ERR;
            endcase
        end
        // ======================================================
        // Position tracking and armed overrides
        for (int i = 0; i < 2; i++) begin
            if (pos_step[i]) begin
                n.pos[i] = pos_dir[i] ? st.pos[i] - 32'h1
                    : st.pos[i] + 32'h1;
            end
            if (st.arm[i] && st.pos[i] == st.trig[i]) begin
                n.spd_load[i] = 1'b1;
                n.arm[i] = 1'b0;
            end else if (!axis_moving[i]) begin
                n.arm[i] = 1'b0;
            end
        end
        // ======================================================
        // Command execution, one per write, emergency first
        a = n.sel;
        spd_ok = st.arg1 >= 32'(paxc_pkg::SPD_MIN)
            && st.arg1 <= 32'(paxc_pkg::SPD_MAX);
        step_ok = st.arg0 >= 32'(paxc_pkg::STEP_MIN)
            && st.arg0 <= 32'(paxc_pkg::STEP_MAX);
        if (go[paxc_pkg::B_EMG]) begin
            cmd = paxc_pkg::C_EMG;
        end else if (go[paxc_pkg::B_PSO]) begin
            cmd = paxc_pkg::C_PSO;
        end else if (go[paxc_pkg::B_INC]) begin
            cmd = paxc_pkg::C_INC;
        end else if (go[paxc_pkg::B_SNS]) begin
            cmd = paxc_pkg::C_SNS;
        end else if (go[paxc_pkg::B_MOF]) begin
            cmd = paxc_pkg::C_MOF;
        end else if (go[paxc_pkg::B_PRS]) begin
            cmd = paxc_pkg::C_PRS;
        end else if (go[paxc_pkg::B_REL]) begin
            cmd = paxc_pkg::C_REL;
        end
        if (cmd != paxc_pkg::C_NONE) begin
            n.done = 1'b1;
            n.code = paxc_pkg::E_OK;
        end
        unique case (cmd)
            paxc_pkg::C_NONE: begin
            end
            paxc_pkg::C_EMG: begin
                n.halt = 2'b11;
                n.emg = 2'b11;
                n.arm = 2'b00;
                n.code = paxc_pkg::E_EMG;
                n.inh = 2'b11;
                n.home = 2'b00;
            end
            paxc_pkg::C_PSO: begin
                if (axis_moving[a] && !axis_decel[a] && !axis_dwell[a]
                    && spd_ok) begin
                    n.arm[a] = 1'b1;
                    n.trig[a] = st.arg0;
                    n.spd[a] = st.arg1[16:0];
                end
            end
            paxc_pkg::C_INC: begin
                if (axis_moving[a]) begin
                    n.code = paxc_pkg::E_INC_BUSY;
                end else if (st.inh[a]) begin
                    n.code = paxc_pkg::E_INC_INH;
                end else begin
                    // distance out, speed from inching register
                    n.inch_go[a] = 1'b1;
                    n.inch_dist = st.arg0;
                end
            end
            paxc_pkg::C_SNS: begin
                if (axis_moving[a]) begin
                    n.code = paxc_pkg::E_SNS_BUSY;
                end else if (!step_ok) begin
                    n.code = paxc_pkg::E_SNS_RNG;
                end else begin
                    n.step[a] = st.arg0[6:0];
                end
            end
            paxc_pkg::C_MOF: begin
                n.mact[a] = 1'b0;
                n.mnum[a] = '0;
            end
            paxc_pkg::C_PRS: begin
                if (axis_moving[a]) begin
                    n.code = paxc_pkg::E_PRS_BUSY;
                end else begin
                    n.pos[a] = st.arg0;
                    n.home[a] = 1'b1;
                end
            end
            paxc_pkg::C_REL: begin
                n.inh[a] = 1'b0;
                n.emg[a] = 1'b0;
            end
        endcase
        // New aux code wins over a release in the same cycle
        for (int i = 0; i < 2; i++) begin
            if (mcode_set[i]) begin
                n.mact[i] = 1'b1;
                n.mnum[i] = mcode_value;
            end
        end
        // Sticky events set after the clear, so set wins
        if (n.done) begin
            n.irq_st[paxc_pkg::I_DONE] = 1'b1;
            if (n.code != paxc_pkg::E_OK) begin
                n.irq_st[paxc_pkg::I_ERR] = 1'b1;
            end
        end
        // Registered level, so the pin cannot glitch
        n.irq_lvl = |(n.irq_st & n.irq_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.inch_spd <= paxc_pkg::INCH_SPD_RST;
            st.step <= {paxc_pkg::STEP_MIN, paxc_pkg::STEP_MIN};
        end else begin
            st <= n;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_emg;
        cmd == paxc_pkg::C_EMG |=> st.halt == 2'b11 && st.emg == 2'b11
            && st.code == paxc_pkg::E_EMG ##1 st.halt == 2'b00;
    endproperty
    a_emg: assert property (p_emg)
        else $error("emergency halt not applied");

    property p_emg_home;
        cmd == paxc_pkg::C_EMG |=> st.inh == 2'b11 && st.home == 2'b00;
    endproperty
    a_emg_home: assert property (p_emg_home)
        else $error("inhibit or home loss missing");

    property p_inh_hold;
        st.inh[0] && !(cmd == paxc_pkg::C_REL && !n.sel) |=> st.inh[0];
    endproperty
    a_inh_hold: assert property (p_inh_hold)
        else $error("inhibit dropped without release");

    property p_pso_ign;
        cmd == paxc_pkg::C_PSO && (axis_decel[n.sel] || axis_dwell[n.sel])
            |=> st.code == paxc_pkg::E_OK && st.trig == $past(st.trig);
    endproperty
    a_pso_ign: assert property (p_pso_ign)
        else $error("override taken while decelerating");

    property p_pso_fire;
        st.arm[0] && st.pos[0] == st.trig[0]
            |=> st.spd_load[0] && st.spd[0] == $past(st.spd[0]);
    endproperty
    a_pso_fire: assert property (p_pso_fire)
        else $error("speed not swapped at trigger");

    property p_inch;
        cmd == paxc_pkg::C_INC && !axis_moving[n.sel] && !st.inh[n.sel]
            |=> st.inch_go[st.sel] && st.inch_dist == $past(st.arg0)
            ##1 st.inch_go == 2'b00;
    endproperty
    a_inch: assert property (p_inch)
        else $error("inching not started");

    property p_inch_ref;
        cmd == paxc_pkg::C_INC && (axis_moving[n.sel] || st.inh[n.sel])
            |=> st.inch_go == 2'b00 && (st.code == paxc_pkg::E_INC_BUSY
            || st.code == paxc_pkg::E_INC_INH);
    endproperty
    a_inch_ref: assert property (p_inch_ref)
        else $error("inching not refused");

    property p_sns;
        cmd == paxc_pkg::C_SNS && (axis_moving[n.sel] || !step_ok)
            |=> st.step == $past(st.step) && st.code != paxc_pkg::E_OK;
    endproperty
    a_sns: assert property (p_sns)
        else $error("bad step change altered step");

    property p_mof;
        cmd == paxc_pkg::C_MOF && !mcode_set[n.sel]
            |=> !st.mact[st.sel] && st.mnum[st.sel] == '0;
    endproperty
    a_mof: assert property (p_mof)
        else $error("aux code not released");

    property p_prs;
        cmd == paxc_pkg::C_PRS && !axis_moving[n.sel]
            |=> st.pos[st.sel] == $past(st.arg0) && st.home[st.sel];
    endproperty
    a_prs: assert property (p_prs)
        else $error("preset not applied");

    property p_prs_busy;
        cmd == paxc_pkg::C_PRS && axis_moving[n.sel]
            |=> st.code == paxc_pkg::E_PRS_BUSY;
    endproperty
    a_prs_busy: assert property (p_prs_busy)
        else $error("preset on moving axis not refused");

    property p_done;
        wr && st.awaddr == paxc_pkg::A_CMD && st.wstrb[0]
            && (st.wdata[6:0] & ~st.req) != '0 |=> st.done ##1 !st.done;
    endproperty
    a_done: assert property (p_done)
        else $error("done pulse missing");
endmodule

//--- hdl/paxc_pkg.sv
// Constants for the two-axis positioning command handler
// Function
// - Armed override loads requested speed (1..100000) when position equals trigger
// - Override taken only in accel or constant speed; else ignored, no error
// - Inching moves selected axis by signed distance at configured inching speed
// - Inching refused: 401 if axis moving, 402 if output inhibited
// - Start step change loads requested step, valid 1 through 80
// - Step change refused unchanged: 441 if moving, 442 if out of range
// - Aux code release clears active flag and stored code number
// - Preset overwrites present position with signed 32-bit value
// - Preset marks home as determined
// - Preset refused on moving axis, position kept, code 451
// - Emergency halts both axes at once, sets halt flags, code 481
// - After emergency, output inhibited and home undetermined until re-established
package paxc_pkg;
    // Register byte addresses
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_ARG0 = 8'h04;
    localparam logic [7:0] A_ARG1 = 8'h08;
    localparam logic [7:0] A_INCH = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_IRQS = 8'h14;
    localparam logic [7:0] A_IRQM = 8'h18;
    localparam logic [7:0] A_FLAG = 8'h1c;
    localparam logic [7:0] A_POSX = 8'h20;
    localparam logic [7:0] A_POSY = 8'h24;
    localparam logic [7:0] A_MCODE = 8'h28;
    localparam logic [7:0] A_STEP = 8'h2c;
    // Command register bit positions
    localparam int B_PSO = 0;
    localparam int B_INC = 1;
    localparam int B_SNS = 2;
    localparam int B_MOF = 3;
    localparam int B_PRS = 4;
    localparam int B_EMG = 5;
    localparam int B_REL = 6;
    localparam int B_SEL = 8;
    localparam int NREQ = 7;
    // Status codes
    localparam logic [9:0] E_OK = 10'h000;
    localparam logic [9:0] E_INC_BUSY = 10'h191;
    localparam logic [9:0] E_INC_INH = 10'h192;
    localparam logic [9:0] E_SNS_BUSY = 10'h1b9;
    localparam logic [9:0] E_SNS_RNG = 10'h1ba;
    localparam logic [9:0] E_PRS_BUSY = 10'h1c3;
    localparam logic [9:0] E_EMG = 10'h1e1;
    // Ranges and reset values
    localparam logic [16:0] SPD_MIN = 17'h00001;
    localparam logic [16:0] SPD_MAX = 17'h186a0;
    localparam logic [6:0] STEP_MIN = 7'h01;
    localparam logic [6:0] STEP_MAX = 7'h50;
    localparam logic [16:0] INCH_SPD_RST = 17'h00001;
    localparam int I_DONE = 0;
    localparam int I_ERR = 1;
    localparam logic [1:0] RESP_OK = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;
    typedef enum logic [2:0] {
        C_NONE, C_EMG, C_PSO, C_INC, C_SNS, C_MOF, C_PRS, C_REL
    } paxc_cmd_e;
endpackage

//--- sim/paxc_axis_model.sv
// Behavioural model of the two axis pulse engines
`timescale 1ns/1ps
module paxc_axis_model #(
    parameter int MCW = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] go,
    input wire logic [1:0] dec,
    input wire logic [1:0] dwl,
    input wire logic step_en,
    input wire logic [1:0] mset,
    input wire logic [MCW-1:0] mval,
    input wire logic [1:0] halt_pulse,
    input wire logic [1:0] output_inhibit,
    output logic [1:0] axis_moving,
    output logic [1:0] axis_decel,
    output logic [1:0] axis_dwell,
    output logic [1:0] pos_step,
    output logic [1:0] pos_dir,
    output logic [1:0] mcode_set,
    output logic [MCW-1:0] mcode_value
);
    // ==========================================
    // Axis state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            axis_moving <= 2'h0;
            axis_decel <= 2'h0;
            axis_dwell <= 2'h0;
            pos_step <= 2'h0;
            pos_dir <= 2'h0;
            mcode_set <= 2'h0;
            mcode_value <= '0;
        end else begin
            axis_moving <= (halt_pulse != 2'h0) ? 2'h0 : go & ~output_inhibit;
            axis_decel <= dec & axis_moving;
            axis_dwell <= dwl & axis_moving;
            pos_step <= {1'b0, step_en & axis_moving[0]};
            pos_dir <= 2'h0;
            mcode_set <= mset;
            // Idle code lines toggle, so a stale value never looks valid
            mcode_value <= (mset != 2'h0) ? mval : ~mcode_value;
        end
    end
endmodule

//--- sim/tb_paxc_core.sv
// Self-checking bench for the positioning command handler
`timescale 1ns/1ps
module tb_paxc_core;
    // ==========================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic bready = 1'b1, rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    wire logic awready, wready, bvalid, arready, rvalid, irq, done;
    wire logic [1:0] bresp, rresp, moving, decel, dwell, pstep, pdir;
    wire logic [1:0] mset_o, halt, inh, sload, istart, home;
    wire logic [31:0] rdata, idist;
    wire logic [9:0] status;
    wire logic [1:0][16:0] ospd;
    wire logic [1:0][6:0] stepn;
    wire logic [16:0] ispd;
    wire logic [15:0] mval_o;
    logic [1:0] go = 2'h0, dec = 2'h0, dwl = 2'h0, mset = 2'h0;
    logic step_en = 1'b0;
    logic [15:0] mval = 16'h0;
    logic [1:0] exp_b = 2'h0;
    logic [33:0] rd_q[$], st_q[$], ev_q[$];
    int n_mismatch = 0, tests_run = 0;
    logic [31:0] v, d;
    logic [16:0] spd;

    always #12.5 aclk = ~aclk;

    paxc_core #(.MCW(16)) paxc_core_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .axis_moving(moving),
        .axis_decel(decel), .axis_dwell(dwell), .pos_step(pstep),
        .pos_dir(pdir), .mcode_set(mset_o), .mcode_value(mval_o),
        .halt_pulse(halt), .output_inhibit(inh), .speed_load(sload),
        .override_speed(ospd), .inch_start(istart),
        .inching_distance(idist), .inching_speed(ispd),
        .step_number(stepn), .home_determined(home), .cmd_done(done),
        .cmd_status(status), .irq(irq));

    paxc_axis_model #(.MCW(16)) paxc_axis_model_i (.aclk(aclk),
        .aresetn(aresetn), .go(go), .dec(dec), .dwl(dwl),
        .step_en(step_en), .mset(mset), .mval(mval), .halt_pulse(halt),
        .output_inhibit(inh), .axis_moving(moving), .axis_decel(decel),
        .axis_dwell(dwell), .pos_step(pstep), .pos_dir(pdir),
        .mcode_set(mset_o), .mcode_value(mval_o));

    // ==========================================
    // Tasks
    task automatic results;
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tmo;
        n_mismatch++;
        results();
    endtask

    task automatic cmp(input string nm, input logic [33:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        int n;
        awaddr <= a;
        wdata <= x;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 64) tmo();
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rd_q.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 64) tmo();
    endtask

    task automatic cmd(input int b, input logic ax, input logic [31:0] arg,
                       input logic [9:0] e);
        wr(paxc_pkg::A_ARG0, arg);
        st_q.push_back({24'h0, e});
        wr(paxc_pkg::A_CMD, (32'(ax) << paxc_pkg::B_SEL) | (32'h1 << b));
        wr(paxc_pkg::A_CMD, 32'h0);
    endtask

    task automatic drain;
        int n;
        for (n = 0; n < 500; n++) begin
            if (ev_q.size() == 0) break;
            @(posedge aclk);
        end
        if (n == 500) tmo();
    endtask

    // ==========================================
    // Output watcher, oldest note first
    always @(posedge aclk) begin
        if (aresetn) begin
            if (rvalid)
                cmp("read", rd_q.size() ? rd_q.pop_front() : '1,
                    {rresp, rdata});
            if (bvalid) cmp("bresp", 34'(exp_b), 34'(bresp));
            if (done)
                cmp("status", st_q.size() ? st_q.pop_front() : '1,
                    34'(status));
            if (sload != 2'h0)
                cmp("speed", ev_q.size() ? ev_q.pop_front() : '1,
                    {15'h0, sload, ospd[0]});
            if (halt != 2'h0)
                cmp("halt", ev_q.size() ? ev_q.pop_front() : '1, 34'(halt));
            if (istart != 2'h0)
                cmp("inch", ev_q.size() ? ev_q.pop_front() : '1,
                    {istart, idist});
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h87f5552a));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(paxc_pkg::A_STEP, 34'h0101);
        rd(paxc_pkg::A_FLAG, 34'h0);
        rd(8'h30, {paxc_pkg::RESP_ERR, 32'h0});
        exp_b <= paxc_pkg::RESP_ERR;
        wr(8'h30, 32'h1);
        exp_b <= paxc_pkg::RESP_OK;
        wr(paxc_pkg::A_IRQM, 32'h1);
        cmd(paxc_pkg::B_SNS, 1'b0, 32'h50, paxc_pkg::E_OK);
        cmp("irq", 34'h1, 34'(irq));
        wr(paxc_pkg::A_IRQS, 32'h1);
        cmp("irq", 34'h0, 34'(irq));
        cmd(paxc_pkg::B_SNS, 1'b1, 32'h51, paxc_pkg::E_SNS_RNG);
        cmd(paxc_pkg::B_SNS, 1'b1, 32'h0, paxc_pkg::E_SNS_RNG);
        rd(paxc_pkg::A_STEP, 34'h0150);
        cmp("step", 34'h0d0, 34'(stepn));
        v = $urandom;
        cmd(paxc_pkg::B_PRS, 1'b0, v, paxc_pkg::E_OK);
        rd(paxc_pkg::A_POSX, {2'h0, v});
        rd(paxc_pkg::A_FLAG, 34'h10);
        cmp("home", 34'h1, 34'(home));
        go <= 2'h1;
        repeat (2) @(posedge aclk);
        cmd(paxc_pkg::B_SNS, 1'b0, 32'h5, paxc_pkg::E_SNS_BUSY);
        cmd(paxc_pkg::B_PRS, 1'b0, 32'h1, paxc_pkg::E_PRS_BUSY);
        cmd(paxc_pkg::B_INC, 1'b0, 32'h7, paxc_pkg::E_INC_BUSY);
        rd(paxc_pkg::A_POSX, {2'h0, v});
        rd(paxc_pkg::A_STEP, 34'h0150);
        spd = 17'(1 + $urandom % 100000);
        wr(paxc_pkg::A_ARG1, 32'(spd));
        // Trigger equals position: any arming would load at once
        dec <= 2'h1;
        cmd(paxc_pkg::B_PSO, 1'b0, v, paxc_pkg::E_OK);
        dec <= 2'h0;
        dwl <= 2'h1;
        cmd(paxc_pkg::B_PSO, 1'b0, v, paxc_pkg::E_OK);
        dwl <= 2'h0;
        step_en <= 1'b1;
        ev_q.push_back({15'h0, 2'h1, spd});
        cmd(paxc_pkg::B_PSO, 1'b0, v + 32'hc8, paxc_pkg::E_OK);
        drain();
        d = $urandom;
        mval <= d[15:0];
        mset <= 2'h1;
        @(posedge aclk);
        mset <= 2'h0;
        repeat (3) @(posedge aclk);
        rd(paxc_pkg::A_MCODE, {18'h0, d[15:0]});
        rd(paxc_pkg::A_FLAG, 34'h50);
        cmd(paxc_pkg::B_MOF, 1'b0, 32'h0, paxc_pkg::E_OK);
        rd(paxc_pkg::A_MCODE, 34'h0);
        rd(paxc_pkg::A_FLAG, 34'h10);
        ev_q.push_back(34'h3);
        cmd(paxc_pkg::B_EMG, 1'b1, 32'h0, paxc_pkg::E_EMG);
        go <= 2'h0;
        step_en <= 1'b0;
        rd(paxc_pkg::A_FLAG, 34'h0f);
        cmp("inhibit", 34'h3, 34'(inh));
        cmp("home", 34'h0, 34'(home));
        cmd(paxc_pkg::B_INC, 1'b0, 32'h5, paxc_pkg::E_INC_INH);
        cmd(paxc_pkg::B_REL, 1'b0, 32'h0, paxc_pkg::E_OK);
        cmd(paxc_pkg::B_REL, 1'b1, 32'h0, paxc_pkg::E_OK);
        cmp("inhibit", 34'h0, 34'(inh));
        cmd(paxc_pkg::B_PRS, 1'b0, 32'h0, paxc_pkg::E_OK);
        cmp("home", 34'h1, 34'(home));
        wr(paxc_pkg::A_INCH, 32'(spd));
        d = $urandom;
        ev_q.push_back({2'h1, d});
        cmd(paxc_pkg::B_INC, 1'b0, d, paxc_pkg::E_OK);
        cmp("inch speed", 34'(spd), 34'(ispd));
        drain();
        results();
    end
endmodule
